// ---- dpio_top.sv ----
module dpio_top
  import dpio_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // peripheral register access
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // on-chip peripheral sources
  input  wire logic [7:0] general_chip_select_out,
  input  wire logic       serial1_transmit_line,
  input  wire logic       serial1_interrupt_out,
  input  wire logic       serial_transmit_buffer,
  input  wire logic       serial1_mode0_tx_active,
  // peripheral view of pure inputs
  output logic      [3:0] serial_pin_inputs,
  // first port pins
  output logic      [7:0] p1_pin_out,
  // second port pins
  input  wire logic [7:0] p2_pin_in,
  output logic      [7:0] p2_pin_out,
  output logic      [7:0] p2_pin_oe
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] first_port_direction;
  logic [7:0] first_port_source_select;
  logic [7:0] first_port_output_latch;
  logic [7:0] second_port_direction;
  logic [7:0] second_port_source_select;
  logic [7:0] second_port_output_latch;
  logic [7:0] p2_sync1;
  logic [7:0] p2_sync2;
  logic [7:0] first_port_pin_level;
  logic [7:0] second_port_pin_level;
  logic [7:0] next_rdata;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_port_direction      <= DPIO_RST_P1_DIR;
      first_port_source_select  <= DPIO_RST_P1_SEL;
      first_port_output_latch   <= DPIO_RST_P1_LAT;
      second_port_direction     <= DPIO_RST_P2_DIR;
      second_port_source_select <= DPIO_RST_P2_SEL;
      second_port_output_latch  <= DPIO_RST_P2_LAT;
    end
    else if (reg_wr)
    begin
      // single-cycle write; unused bits stay storage
      case (reg_addr)
        DPIO_OFS_P1_DIR: first_port_direction      <= reg_wdata;
        DPIO_OFS_P1_SEL: first_port_source_select  <= reg_wdata;
        DPIO_OFS_P1_LAT: first_port_output_latch   <= reg_wdata;
        DPIO_OFS_P2_DIR: second_port_direction     <= reg_wdata;
        DPIO_OFS_P2_SEL: second_port_source_select <= reg_wdata;
        DPIO_OFS_P2_LAT: second_port_output_latch  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input synchronizer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      p2_sync1 <= DPIO_ZERO8;
      p2_sync2 <= DPIO_ZERO8;
    end
    else
    begin
      p2_sync1 <= p2_pin_in;
      p2_sync2 <= p2_sync1;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_comb
  begin
    // first port: driver never disabled, direction ignored
    p1_pin_out = (first_port_source_select & general_chip_select_out)
               | (~first_port_source_select & first_port_output_latch);
    p2_pin_out = DPIO_ZERO8;
    p2_pin_oe  = DPIO_ZERO8;
    p2_pin_oe[DPIO_B_TX]  = 1'b1;
    p2_pin_oe[DPIO_B_INT] = 1'b1;
    p2_pin_out[DPIO_B_TX]  = second_port_source_select[DPIO_B_TX] ?
                             serial1_transmit_line :
                             second_port_output_latch[DPIO_B_TX];
    p2_pin_out[DPIO_B_INT] = second_port_source_select[DPIO_B_INT] ?
                             serial1_interrupt_out :
                             second_port_output_latch[DPIO_B_INT];
    // receive line drives only while mode 0 transmit is active
    p2_pin_oe[DPIO_B_RX]  = serial1_mode0_tx_active;
    p2_pin_out[DPIO_B_RX] = second_port_source_select[DPIO_B_RX] ?
                            serial_transmit_buffer :
                            second_port_output_latch[DPIO_B_RX];
    // open drain: only ever drives low
    p2_pin_oe[DPIO_B_OD0] = !second_port_direction[DPIO_B_OD0]
                          && !second_port_source_select[DPIO_B_OD0]
                          && !second_port_output_latch[DPIO_B_OD0];
    p2_pin_oe[DPIO_B_OD1] = !second_port_direction[DPIO_B_OD1]
                          && !second_port_source_select[DPIO_B_OD1]
                          && !second_port_output_latch[DPIO_B_OD1];
  end

  // pure inputs feed serial unit through the two-stage synchronizer, no selection
  assign serial_pin_inputs = {p2_sync2[5], p2_sync2[4], p2_sync2[2], p2_sync2[0]};
  assign first_port_pin_level = p1_pin_out;
  // driven bits read their own drive, others the synchronized pad
  assign second_port_pin_level = (p2_pin_oe & p2_pin_out)
                               | (~p2_pin_oe & p2_sync2);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    case (reg_addr)
      DPIO_OFS_P1_DIR: next_rdata = first_port_direction;
      DPIO_OFS_P1_PIN: next_rdata = first_port_pin_level;
      DPIO_OFS_P1_SEL: next_rdata = first_port_source_select;
      DPIO_OFS_P1_LAT: next_rdata = first_port_output_latch;
      DPIO_OFS_P2_DIR: next_rdata = second_port_direction;
      DPIO_OFS_P2_PIN: next_rdata = second_port_pin_level;
      DPIO_OFS_P2_SEL: next_rdata = second_port_source_select;
      DPIO_OFS_P2_LAT: next_rdata = second_port_output_latch;
      default:         next_rdata = DPIO_ZERO8;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= DPIO_ZERO8;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end
endmodule // dpio_top

// ---- dpio_pkg.sv ----
package dpio_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DPIO_OFS_P1_DIR = 8'h50;
  localparam logic [7:0] DPIO_OFS_P1_PIN = 8'h52;
  localparam logic [7:0] DPIO_OFS_P1_SEL = 8'h54;
  localparam logic [7:0] DPIO_OFS_P1_LAT = 8'h56;
  localparam logic [7:0] DPIO_OFS_P2_DIR = 8'h58;
  localparam logic [7:0] DPIO_OFS_P2_PIN = 8'h5A;
  localparam logic [7:0] DPIO_OFS_P2_SEL = 8'h5C;
  localparam logic [7:0] DPIO_OFS_P2_LAT = 8'h5E;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DPIO_RST_P1_DIR = 8'h00;
  localparam logic [7:0] DPIO_RST_P1_SEL = 8'hFF;
  localparam logic [7:0] DPIO_RST_P1_LAT = 8'hFF;
  localparam logic [7:0] DPIO_RST_P2_DIR = 8'hC0;
  localparam logic [7:0] DPIO_RST_P2_SEL = 8'h0B;
  localparam logic [7:0] DPIO_RST_P2_LAT = 8'hFF;
  // ----------------------------------------------------------------
  // second port bit positions
  // ----------------------------------------------------------------
  localparam int DPIO_B_RX  = 0;
  localparam int DPIO_B_TX  = 1;
  localparam int DPIO_B_INT = 3;
  localparam int DPIO_B_OD0 = 6;
  localparam int DPIO_B_OD1 = 7;
  localparam logic [7:0] DPIO_P2_IN_MASK = 8'h35;
  localparam logic [7:0] DPIO_ZERO8      = 8'h00;
endpackage

// ---- dpio_chk.sv ----
module dpio_chk
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       serial1_mode0_tx_active,
  input wire logic [3:0] serial_pin_inputs,
  input wire logic [7:0] p2_pin_in,
  input wire logic [7:0] p2_pin_out,
  input wire logic [7:0] p2_pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_in_pins_float: assert property ((p2_pin_oe & 8'h34) == 8'h00)
    else $error("input-only pin driven");
  a_out_pins_on: assert property ((p2_pin_oe & 8'h0A) == 8'h0A)
    else $error("output pin not driven");
  a_rx_follows_tx: assert property (p2_pin_oe[0] == serial1_mode0_tx_active)
    else $error("receive pin drive wrong");
  a_od_low_only: assert property ((p2_pin_oe & p2_pin_out & 8'hC0) == 8'h00)
    else $error("open-drain pin drove high");
  a_sync_two: assert property ($past(rst_b) && $past(rst_b, 2) |-> serial_pin_inputs ==
      $past({p2_pin_in[5], p2_pin_in[4], p2_pin_in[2], p2_pin_in[0]}, 2)) else $error("sync delay");
  a_rd_unmapped: assert property (reg_rd && (reg_addr[0] || reg_addr[7:4] != 4'h5) |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_rw_readback: assert property (reg_wr && reg_addr[7:4] == 4'h5 && reg_addr[2:0] != 3'h2
      && !reg_addr[0] ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("readback mismatch");
endmodule // dpio_chk
bind dpio_top dpio_chk u_chk (.*);

// ---- dpio_pad_model.sv ----
module dpio_pad_model
(
  input  wire logic [7:0] p2_pin_out,
  input  wire logic [7:0] p2_pin_oe,
  input  wire logic [7:0] far_lvl,
  output logic      [7:0] p2_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pads show the outside source, or the pull-up level on the open-drain pair
  assign p2_pin_in = (p2_pin_oe & p2_pin_out) | (~p2_pin_oe & far_lvl);
endmodule // dpio_pad_model

// ---- tb_top.sv ----
module tb_top
  import dpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       serial1_transmit_line = 1'b1, serial1_interrupt_out = 1'b0;
  logic       serial_transmit_buffer = 1'b0, serial1_mode0_tx_active = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, p1_pin_out, p2_pin_in;
  logic [7:0] general_chip_select_out = 8'hC3, p2_pin_out, p2_pin_oe, far_lvl = 8'hC4;
  logic [3:0] serial_pin_inputs;
  int         n_fail = 0, tests_run = 0, cyc = 0;
  initial forever #20 ref_clk = ~ref_clk;
  dpio_pad_model pads (.*);
  dpio_top dut (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    n_fail += int'(got !== exp);
    if (got !== exp) $display("unexpected at %0t: got %h, want %h", $time, got, exp);
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(negedge ref_clk);
    {reg_wr, reg_rd} = 2'b00;
    if (!w) chk({8'h00, reg_rdata}, {8'h00, d});
  endtask
  task automatic summarize(input logic to);
    n_fail += int'(to);
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) if (++cyc == 3000) summarize(1'b1);
  initial
  begin
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    acc(1'b0, DPIO_OFS_P2_DIR, 8'hC0);
    acc(1'b1, DPIO_OFS_P1_LAT, 8'h5A);
    acc(1'b1, DPIO_OFS_P1_SEL, 8'h0F);
    acc(1'b1, DPIO_OFS_P1_DIR, 8'hA5);
    acc(1'b0, DPIO_OFS_P1_DIR, 8'hA5);
    acc(1'b0, DPIO_OFS_P1_PIN, 8'h53);
    acc(1'b1, DPIO_OFS_P2_LAT, 8'h3D);
    acc(1'b1, DPIO_OFS_P2_DIR, 8'h00);
    acc(1'b1, DPIO_OFS_P2_SEL, 8'h40);
    acc(1'b0, DPIO_OFS_P2_LAT, 8'h3D);
    acc(1'b0, DPIO_OFS_P2_PIN, 8'h4C);
    acc(1'b1, DPIO_OFS_P2_SEL, 8'h0B);
    serial1_mode0_tx_active = 1'b1;
    #1 chk({p2_pin_oe, p2_pin_out & 8'hCB}, 16'hCB02);
    acc(1'b0, 8'h51, 8'h00);
    summarize(1'b0);
  end
endmodule // tb_top
